// file: verilog/rtbfd_decode.sv
// Receive-side BAR match and target function decoder with ready latency two
`timescale 1ns/10ps

module rtbfd_decode #(
    parameter int NUM_PF = rtbfd_pkg::NUM_PF_DEF
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire rtbfd_pkg::rtbfd_pf_cfg_t [NUM_PF-1:0] pf_cfg_i,
    input wire logic in_valid_i,
    input wire logic in_first_i,
    input wire logic in_last_i,
    input wire rtbfd_pkg::rtbfd_hdr_t in_hdr_i,
    output logic in_accept_o,
    input wire logic rx_sink_ready_i,
    output logic rx_beat_valid_o,
    output logic rx_packet_first_beat_o,
    output logic rx_packet_last_beat_o,
    output rtbfd_pkg::rtbfd_side_t side_o
);

    ////////////////////////////////////////////////////////////////////////
    // BAR matchers per physical function, PF windows and VF windows
    logic [NUM_PF-1:0] pf_hit;
    logic [NUM_PF-1:0] vf_hit;
    logic [rtbfd_pkg::CODE_W-1:0] pf_code [NUM_PF];
    logic [rtbfd_pkg::CODE_W-1:0] vf_code [NUM_PF];
    logic [rtbfd_pkg::VF_OFF_W-1:0] vf_idx [NUM_PF];
    logic [rtbfd_pkg::NUM_VFS_W-1:0] vf_count [NUM_PF];

    for (genvar p = 0; p < NUM_PF; p++) begin : g_pf
        assign vf_count[p] = pf_cfg_i[p].vf_en ? pf_cfg_i[p].num_vfs : '0;
        rtbfd_bar_match u_pf (
            .bars_i(pf_cfg_i[p].pf_bar),
            .addr_i(in_hdr_i.addr),
            .count_i(16'h0001),
            .hit_o(pf_hit[p]),
            .code_o(pf_code[p]),
            .index_o()
        );
        rtbfd_bar_match u_vf (
            .bars_i(pf_cfg_i[p].vf_bar),
            .addr_i(in_hdr_i.addr),
            .count_i(vf_count[p]),
            .hit_o(vf_hit[p]),
            .code_o(vf_code[p]),
            .index_o(vf_idx[p])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // First-beat decode
    rtbfd_pkg::rtbfd_side_t dec_side;
    logic [rtbfd_pkg::FN_W-1:0] fn_rel;

    always_comb begin
        dec_side = rtbfd_pkg::SIDE_RESET;
        fn_rel = '0;
        unique case (in_hdr_i.cls)
            rtbfd_pkg::CLS_MEM: begin
                // VF pass first, PF pass after so a PF window takes precedence
                for (int p = NUM_PF - 1; p >= 0; p--) begin
                    if (vf_hit[p]) begin
                        dec_side.bar_match_code = vf_code[p];
                        dec_side.target_phys_fn_index = 3'(p);
                        dec_side.target_is_virtual_fn = 1'b1;
                        dec_side.virtual_fn_offset = vf_idx[p];
                    end
                end
                for (int p = NUM_PF - 1; p >= 0; p--) begin
                    if (pf_hit[p]) begin
                        dec_side.bar_match_code = pf_code[p];
                        dec_side.target_phys_fn_index = 3'(p);
                        dec_side.target_is_virtual_fn = 1'b0;
                        dec_side.virtual_fn_offset = rtbfd_pkg::VF_OFF_RESET;
                    end
                end
            end
            rtbfd_pkg::CLS_CPL, rtbfd_pkg::CLS_MSG_ID: begin
                if (in_hdr_i.dest_fn < 8'(NUM_PF)) begin
                    dec_side.target_phys_fn_index = in_hdr_i.dest_fn[2:0];
                end else begin
                    for (int p = NUM_PF - 1; p >= 0; p--) begin
                        fn_rel = in_hdr_i.dest_fn - pf_cfg_i[p].first_vf_fn;
                        if (in_hdr_i.dest_fn >= pf_cfg_i[p].first_vf_fn
                            && {8'h00, fn_rel} < vf_count[p]) begin
                            dec_side.target_phys_fn_index = 3'(p);
                            dec_side.target_is_virtual_fn = 1'b1;
                            dec_side.virtual_fn_offset = {4'h0, fn_rel};
                        end
                    end
                end
            end
            rtbfd_pkg::CLS_OTHER: begin
                dec_side = rtbfd_pkg::SIDE_RESET;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Ready-latency pipeline and output registers
    logic accept_reg;
    logic accept_next;
    logic valid_reg;
    logic valid_next;
    logic first_reg;
    logic first_next;
    logic last_reg;
    logic last_next;
    rtbfd_pkg::rtbfd_side_t side_reg;
    rtbfd_pkg::rtbfd_side_t side_next;
    logic beat_take;

    assign beat_take = in_valid_i && accept_reg;

    always_comb begin
        // Ready of cycle n opens the source for cycle n+1, output lands at n+2
        accept_next = rx_sink_ready_i;
        valid_next = beat_take;
        first_next = beat_take && in_first_i;
        last_next = beat_take && in_last_i;
        side_next = side_reg;
        // Decode held for the rest of the packet
        if (beat_take && in_first_i) begin
            side_next = dec_side;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            accept_reg <= 1'b0;
            valid_reg <= 1'b0;
            first_reg <= 1'b0;
            last_reg <= 1'b0;
            side_reg <= rtbfd_pkg::SIDE_RESET;
        end else begin
            accept_reg <= accept_next;
            valid_reg <= valid_next;
            first_reg <= first_next;
            last_reg <= last_next;
            side_reg <= side_next;
        end
    end

    assign in_accept_o = accept_reg;
    assign rx_beat_valid_o = valid_reg;
    assign rx_packet_first_beat_o = first_reg;
    assign rx_packet_last_beat_o = last_reg;
    assign side_o = side_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);

    logic take_first;
    logic [rtbfd_pkg::NUM_VFS_W-1:0] sel_count;
    assign take_first = beat_take && in_first_i;

    // VF count of the parent PF named on the output
    always_comb begin
        sel_count = '0;
        for (int p = 0; p < NUM_PF; p++) begin
            if (side_o.target_phys_fn_index == 3'(p)) begin
                sel_count = vf_count[p];
            end
        end
    end

    a_ready_latency: assert property (
        rx_beat_valid_o |-> $past(rx_sink_ready_i, 2))
        else $error("beat sent without ready two cycles earlier");

    a_first_valid: assert property (
        (rx_packet_first_beat_o || rx_packet_last_beat_o) |-> rx_beat_valid_o)
        else $error("packet boundary flag without valid");

    a_code_capture: assert property (
        take_first |=> rx_packet_first_beat_o && side_o == $past(dec_side))
        else $error("decode not presented on first beat");

    a_code_legal: assert property (
        rx_packet_first_beat_o && side_o.bar_match_code != rtbfd_pkg::CODE_NONE
        |-> side_o.bar_match_code < rtbfd_pkg::CODE_FIRST_RSVD)
        else $error("reserved BAR code driven");

    a_pf_bar_hit: assert property (
        take_first && in_hdr_i.cls == rtbfd_pkg::CLS_MEM && pf_hit[0]
        |=> !side_o.target_is_virtual_fn && side_o.target_phys_fn_index == 3'h0
            && side_o.bar_match_code == $past(pf_code[0]))
        else $error("PF0 BAR hit not reported as PF0");

    a_odd_reserved: assert property (
        pf_hit[0] && pf_code[0][0]
        |-> !pf_cfg_i[0].pf_bar[pf_code[0] - 3'h1].is64)
        else $error("odd BAR of a 64-bit pair matched");

    a_vf_range: assert property (
        rx_packet_first_beat_o && side_o.target_is_virtual_fn
        |-> {4'h0, side_o.virtual_fn_offset} < sel_count)
        else $error("VF offset outside parent VF count");

    a_other_idle: assert property (
        take_first && in_hdr_i.cls == rtbfd_pkg::CLS_OTHER
        |=> side_o == rtbfd_pkg::SIDE_RESET)
        else $error("function outputs set for unrelated TLP");

    a_pf_direct: assert property (
        take_first && in_hdr_i.cls == rtbfd_pkg::CLS_CPL && in_hdr_i.dest_fn < 8'(NUM_PF)
        |=> !side_o.target_is_virtual_fn
            && side_o.target_phys_fn_index == $past(in_hdr_i.dest_fn[2:0]))
        else $error("completion routed to wrong PF");

    c_pf_mem: cover property (take_first && in_hdr_i.cls == rtbfd_pkg::CLS_MEM && pf_hit[0]);
    c_vf_mem: cover property (take_first && in_hdr_i.cls == rtbfd_pkg::CLS_MEM && vf_hit != '0);
    c_vf_cpl: cover property (rx_packet_first_beat_o && side_o.target_is_virtual_fn
        && $past(in_hdr_i.cls) == rtbfd_pkg::CLS_CPL);
    c_stall: cover property (rx_sink_ready_i ##1 !rx_sink_ready_i ##2 !rx_beat_valid_o);

endmodule

// file: verilog/rtbfd_pkg.sv
// Shared constants and types for the receive BAR and function decoder
package rtbfd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int NUM_BARS = 6;
    localparam int ADDR_W = 64;
    localparam int CODE_W = 3;
    localparam int PF_IDX_W = 3;
    localparam int VF_OFF_W = 12;
    localparam int NUM_VFS_W = 16;
    localparam int FN_W = 8;
    localparam int NUM_PF_DEF = 4;
    localparam int READY_LATENCY = 2;

    ////////////////////////////////////////////////////////////////////////
    // Codes and reset values
    localparam logic [CODE_W-1:0] CODE_NONE = 3'h7;
    localparam logic [CODE_W-1:0] CODE_FIRST_RSVD = 3'h6;
    localparam logic [PF_IDX_W-1:0] PF_IDX_RESET = 3'h0;
    localparam logic [VF_OFF_W-1:0] VF_OFF_RESET = 12'h000;
    localparam logic [31:0] HI_WORD_ZERO = 32'h0000_0000;

    // Class of a received TLP, decoded by the transaction layer
    typedef enum logic [1:0] {
        CLS_OTHER = 2'h0,
        CLS_MEM = 2'h1,
        CLS_CPL = 2'h2,
        CLS_MSG_ID = 2'h3
    } rtbfd_cls_t;

    // One BAR window: size is 2**aper_log2; for VF BARs that is one VF aperture
    typedef struct packed {
        logic en;
        logic is64;
        logic [5:0] aper_log2;
        logic [ADDR_W-1:0] base;
    } rtbfd_bar_cfg_t;

    typedef struct packed {
        rtbfd_bar_cfg_t [NUM_BARS-1:0] pf_bar;
        rtbfd_bar_cfg_t [NUM_BARS-1:0] vf_bar;
        logic vf_en;
        logic [NUM_VFS_W-1:0] num_vfs;
        logic [FN_W-1:0] first_vf_fn;
    } rtbfd_pf_cfg_t;

    // Header fields of the first beat
    typedef struct packed {
        rtbfd_cls_t cls;
        logic [ADDR_W-1:0] addr;
        logic [FN_W-1:0] dest_fn;
    } rtbfd_hdr_t;

    // Sideband steering presented with each TLP
    typedef struct packed {
        logic [CODE_W-1:0] bar_match_code;
        logic [PF_IDX_W-1:0] target_phys_fn_index;
        logic target_is_virtual_fn;
        logic [VF_OFF_W-1:0] virtual_fn_offset;
    } rtbfd_side_t;

    localparam rtbfd_side_t SIDE_RESET = '{
        bar_match_code: CODE_NONE,
        target_phys_fn_index: PF_IDX_RESET,
        target_is_virtual_fn: 1'b0,
        virtual_fn_offset: VF_OFF_RESET
    };

endpackage

// file: verilog/rtbfd_bar_match.sv
// Address match against the six BAR windows of one function set
`timescale 1ns/10ps
module rtbfd_bar_match (
    input wire rtbfd_pkg::rtbfd_bar_cfg_t [rtbfd_pkg::NUM_BARS-1:0] bars_i,
    input wire logic [rtbfd_pkg::ADDR_W-1:0] addr_i,
    input wire logic [rtbfd_pkg::NUM_VFS_W-1:0] count_i,
    output logic hit_o,
    output logic [rtbfd_pkg::CODE_W-1:0] code_o,
    output logic [rtbfd_pkg::VF_OFF_W-1:0] index_o
);

    // Slot number of the address inside a window, or all ones if below it
    function automatic logic [rtbfd_pkg::ADDR_W-1:0] slot_of(
        input rtbfd_pkg::rtbfd_bar_cfg_t bar,
        input logic [rtbfd_pkg::ADDR_W-1:0] addr
    );
        logic [rtbfd_pkg::ADDR_W-1:0] base;
        base = bar.is64 ? bar.base : {rtbfd_pkg::HI_WORD_ZERO, bar.base[31:0]};
        if (addr < base) begin
            slot_of = '1;
        end else begin
            slot_of = (addr - base) >> bar.aper_log2;
        end
    endfunction

    logic [rtbfd_pkg::ADDR_W-1:0] slot;
    logic usable;

    always_comb begin
        hit_o = 1'b0;
        code_o = rtbfd_pkg::CODE_NONE;
        index_o = '0;
        slot = '0;
        usable = 1'b0;
        // Descending walk so the lowest matching BAR wins
        for (int i = rtbfd_pkg::NUM_BARS - 1; i >= 0; i--) begin
            // Odd BAR is swallowed by a 64-bit pair
            usable = bars_i[i].en && !((i % 2 == 1) && bars_i[i - (i % 2)].is64);
            // 32-bit window only decodes 32-bit addresses
            if (!bars_i[i].is64 && addr_i[63:32] != rtbfd_pkg::HI_WORD_ZERO) begin
                usable = 1'b0;
            end
            slot = slot_of(bars_i[i], addr_i);
            if (usable && slot < {48'h0, count_i}) begin
                hit_o = 1'b1;
                code_o = 3'(i);
                index_o = slot[rtbfd_pkg::VF_OFF_W-1:0];
            end
        end
    end

endmodule

// file: verif/rtbfd_app_sink.sv
// Application-side sink model: drives ready and watches stream timing
`timescale 1ns/10ps
module rtbfd_app_sink (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic slow_i,
    input wire logic rx_beat_valid_i,
    input wire logic rx_first_i,
    input wire logic rx_last_i,
    output logic rx_sink_ready_o,
    output logic err_o
);
    logic [1:0] phase = 2'h0;
    logic rdy_d1;
    logic rdy_d2;

    // The BAR match code is not an input here: this sink never looks at it
    // Slow mode offers ready one cycle in three
    initial rx_sink_ready_o = 1'b0;
    always @(negedge clock_i) begin
        phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
        rx_sink_ready_o <= resetn_i && (!slow_i || phase == 2'h0);
    end

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clock_i) begin
        if (!resetn_i) begin
            rdy_d1 <= 1'b0;
            rdy_d2 <= 1'b0;
            err_o <= 1'b0;
        end else begin
            rdy_d1 <= rx_sink_ready_o;
            rdy_d2 <= rdy_d1;
            if (rx_beat_valid_i && !rdy_d2) err_o <= 1'b1;
            if ((rx_first_i || rx_last_i) && !rx_beat_valid_i) err_o <= 1'b1;
        end
    end
endmodule

// file: verif/test_rtbfd_decode.sv
// Testbench for the receive BAR and function decoder
`timescale 1ns/10ps
module test_rtbfd_decode;
    localparam int NP = 4;
    logic clock_i;
    logic resetn_i;
    rtbfd_pkg::rtbfd_pf_cfg_t [NP-1:0] pf_cfg_i;
    logic in_valid_i;
    logic in_first_i;
    logic in_last_i;
    rtbfd_pkg::rtbfd_hdr_t in_hdr_i;
    logic in_accept_o;
    logic rx_sink_ready_i;
    logic rx_beat_valid_o;
    logic rx_packet_first_beat_o;
    logic rx_packet_last_beat_o;
    rtbfd_pkg::rtbfd_side_t side_o;
    logic slow;
    logic sink_err;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;

    rtbfd_decode #(.NUM_PF(NP)) u_rtbfd_decode (.clock_i(clock_i), .resetn_i(resetn_i),
        .pf_cfg_i(pf_cfg_i), .in_valid_i(in_valid_i), .in_first_i(in_first_i),
        .in_last_i(in_last_i), .in_hdr_i(in_hdr_i), .in_accept_o(in_accept_o),
        .rx_sink_ready_i(rx_sink_ready_i), .rx_beat_valid_o(rx_beat_valid_o),
        .rx_packet_first_beat_o(rx_packet_first_beat_o),
        .rx_packet_last_beat_o(rx_packet_last_beat_o), .side_o(side_o));
    rtbfd_app_sink u_rtbfd_app_sink (.clock_i(clock_i), .resetn_i(resetn_i), .slow_i(slow),
        .rx_beat_valid_i(rx_beat_valid_o), .rx_first_i(rx_packet_first_beat_o),
        .rx_last_i(rx_packet_last_beat_o), .rx_sink_ready_o(rx_sink_ready_i), .err_o(sink_err));

    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails = fails + 1;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    function automatic rtbfd_pkg::rtbfd_bar_cfg_t bar(input logic w64, input logic [63:0] base);
        bar = '{en: 1'b1, is64: w64, aper_log2: w64 ? 6'h10 : 6'h0C, base: base};
    endfunction

    // One packet of n beats; the header is inverted after every taken beat, so odd-numbered beats see it restored
    task automatic send_pkt(input rtbfd_pkg::rtbfd_cls_t cls, input logic [63:0] addr,
        input logic [7:0] fn, input int n, input logic [2:0] code, input logic [2:0] pf,
        input logic vf, input logic [11:0] off);
        int sent;
        int waits;
        logic taken;
        sent = 0;
        waits = 0;
        @(negedge clock_i);
        in_hdr_i = '{cls: cls, addr: addr, dest_fn: fn};
        in_valid_i = 1'b1;
        in_first_i = 1'b1;
        in_last_i = (n == 1);
        while (sent < n && waits < 60) begin
            // Accept is a flop: its value in the low phase is the one used at the edge
            taken = in_accept_o;
            @(posedge clock_i);
            @(negedge clock_i);
            waits++;
            check("beat valid", 12'(rx_beat_valid_o), 12'(taken));
            if (taken === 1'b1) begin
                sent++;
                check("first flag", 12'(rx_packet_first_beat_o), 12'(sent == 1));
                check("last flag", 12'(rx_packet_last_beat_o), 12'(sent == n));
                check("bar code", 12'(side_o.bar_match_code), 12'(code));
                check("pf index", 12'(side_o.target_phys_fn_index), 12'(pf));
                check("vf flag", 12'(side_o.target_is_virtual_fn), 12'(vf));
                if (vf) check("vf offset", side_o.virtual_fn_offset, off);
                in_hdr_i = ~in_hdr_i;
                in_first_i = 1'b0;
                in_last_i = (sent == n - 1);
                in_valid_i = (sent < n);
            end
        end
        check("beats sent", 12'(sent), 12'(n));
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        check("valid in reset", 12'(rx_beat_valid_o), 12'h000);
        check("accept in reset", 12'(in_accept_o), 12'h000);
        check("code in reset", 12'(side_o.bar_match_code), 12'(rtbfd_pkg::CODE_NONE));
        $display("test_reset done");
    endtask

    task automatic test_pf_bars();
        logic [63:0] addr [9] = '{64'h1000_0010, 64'h2000_0FFC, 64'h10_0000_FFF0,
            64'h4000_0000, 64'h3000_0000, 64'h3001_0FFF, 64'h3001_1000, 64'h1_1000_0010,
            64'h5000_0004};
        logic [2:0] code [9] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h4, 3'h5, 3'h7, 3'h7, 3'h0};
        for (int i = 0; i < 9; i++) begin
            send_pkt(rtbfd_pkg::CLS_MEM, addr[i], 8'h00, 1, code[i], (i == 8) ? 3'h1 : 3'h0,
                1'b0, 12'h000);
        end
        $display("test_pf_bars done");
    endtask

    task automatic test_vf_mem();
        slow = 1'b1;
        send_pkt(rtbfd_pkg::CLS_MEM, 64'h6000_3010, 8'h00, 3, 3'h0, 3'h1, 1'b1, 12'h003);
        send_pkt(rtbfd_pkg::CLS_MEM, 64'h6000_0000, 8'h00, 1, 3'h0, 3'h1, 1'b1, 12'h000);
        send_pkt(rtbfd_pkg::CLS_MEM, 64'h6000_4000, 8'h00, 2, 3'h7, 3'h0, 1'b0, 12'h000);
        slow = 1'b0;
        $display("test_vf_mem done");
    endtask

    task automatic test_id_routed();
        send_pkt(rtbfd_pkg::CLS_CPL, 64'h0, 8'h02, 1, 3'h7, 3'h2, 1'b0, 12'h000);
        send_pkt(rtbfd_pkg::CLS_CPL, 64'h0, 8'h09, 2, 3'h7, 3'h1, 1'b1, 12'h001);
        send_pkt(rtbfd_pkg::CLS_MSG_ID, 64'h0, 8'h0B, 1, 3'h7, 3'h1, 1'b1, 12'h003);
        send_pkt(rtbfd_pkg::CLS_MSG_ID, 64'h0, 8'h00, 1, 3'h7, 3'h0, 1'b0, 12'h000);
        $display("test_id_routed done");
    endtask

    task automatic test_other();
        send_pkt(rtbfd_pkg::CLS_OTHER, 64'h1000_0010, 8'h09, 2, 3'h7, 3'h0, 1'b0, 12'h000);
        check("sink protocol", 12'(sink_err), 12'h000);
        $display("test_other done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        slow = 1'b0;
        resetn_i = 1'b0;
        in_valid_i = 1'b0;
        in_first_i = 1'b0;
        in_last_i = 1'b0;
        in_hdr_i = '0;
        pf_cfg_i = '0;
        pf_cfg_i[0].pf_bar[0] = bar(1'b0, 64'h1000_0000);
        pf_cfg_i[0].pf_bar[1] = bar(1'b0, 64'h2000_0000);
        pf_cfg_i[0].pf_bar[2] = bar(1'b1, 64'h10_0000_0000);
        pf_cfg_i[0].pf_bar[3] = bar(1'b0, 64'h4000_0000);
        pf_cfg_i[0].pf_bar[4] = bar(1'b0, 64'h3000_0000);
        pf_cfg_i[0].pf_bar[5] = bar(1'b0, 64'h3001_0000);
        pf_cfg_i[1].pf_bar[0] = bar(1'b0, 64'h5000_0000);
        pf_cfg_i[1].vf_bar[0] = bar(1'b0, 64'h6000_0000);
        pf_cfg_i[1].vf_en = 1'b1;
        pf_cfg_i[1].num_vfs = 16'h0004;
        pf_cfg_i[1].first_vf_fn = 8'h08;
        repeat (3) @(negedge clock_i);
        test_reset();
        repeat (2) @(negedge clock_i);
        resetn_i = 1'b1;
        test_pf_bars();
        test_vf_mem();
        test_id_routed();
        test_other();
        complete_run();
    end
endmodule
